// ### common/bmd_consts.svh
// opcode, prefix, length and cycle constants for the branch and misc decoder
`ifndef BMD_CONSTS_SVH
`define BMD_CONSTS_SVH
`define BMD_PFX_IND 8'h92
`define BMD_OP_JR_BASE 8'h20
`define BMD_OP_CALL_REL 8'had
`define BMD_OP_MUL 8'h42
`define BMD_OP_LD_XA 8'h97
`define BMD_OP_LD_AX 8'h9f
`define BMD_OP_LD_SA 8'h95
`define BMD_OP_LD_AS 8'h9e
`define BMD_OP_LD_SX 8'h94
`define BMD_OP_LD_XS 8'h96
`define BMD_OP_LD_XY 8'h93
`define BMD_OP_PUSH_A 8'h88
`define BMD_OP_POP_A 8'h84
`define BMD_OP_PUSH_X 8'h89
`define BMD_OP_POP_X 8'h85
`define BMD_OP_PUSH_CC 8'h8a
`define BMD_OP_POP_CC 8'h86
`define BMD_OP_RCF 8'h98
`define BMD_OP_SCF 8'h99
`define BMD_OP_RIM 8'h9a
`define BMD_OP_SIM 8'h9b
`define BMD_OP_RSP 8'h9c
`define BMD_OP_NOP 8'h9d
`define BMD_OP_INTERRUPT_EXIT 8'h80
`define BMD_OP_RET 8'h81
`define BMD_OP_TRAP 8'h83
`define BMD_OP_HALT 8'h8e
`define BMD_OP_WFI 8'h8f
`define BMD_LEN_REL 3'h2
`define BMD_LEN_IND 3'h3
`define BMD_LEN_ONE 3'h1
`define BMD_CYC_REL 4'h3
`define BMD_CYC_IND 4'h5
`define BMD_CYC_CALL 4'h6
`define BMD_CYC_CALL_IND 4'h8
`define BMD_CYC_MUL 4'hb
`define BMD_CYC_TWO 4'h2
`define BMD_CYC_PUSH 4'h3
`define BMD_CYC_POP 4'h4
`define BMD_CYC_INTERRUPT_EXIT 4'h9
`define BMD_CYC_RET 4'h6
`define BMD_CYC_TRAP 4'ha
`endif

// ### common/bmd_pkg.sv
// types shared by the branch and misc decoder
`default_nettype none
package bmd_pkg;
  typedef enum logic [4:0] {
    BMD_ILLEGAL, BMD_BRANCH, BMD_CALL_REL, BMD_PRODUCT, BMD_MOVE, BMD_PUSH, BMD_POP,
    BMD_FLAG, BMD_SP_REINIT, BMD_NOP, BMD_INT_EXIT, BMD_SUB_EXIT, BMD_TRAP, BMD_HALT,
    BMD_WAIT
  } bmd_class_t;
  typedef enum logic [2:0] {
    BMD_R_NONE, BMD_R_A, BMD_R_X, BMD_R_Y, BMD_R_SP, BMD_R_CC
  } bmd_reg_t;
  typedef struct packed {
    logic carry;
    logic zero;
    logic neg;
    logic half;
    logic imask;
  } bmd_flags_t;
  typedef struct packed {
    logic valid;
    bmd_class_t cls;
    logic indirect;
    logic [2:0] length;
    logic [3:0] cycles;
    logic taken;
    bmd_reg_t src;
    bmd_reg_t dst;
    logic flag_val;
  } bmd_dec_t;
endpackage : bmd_pkg
`default_nettype wire

// ### verilog/bmd_cond.sv
// branch condition evaluation for opcodes 20..2f
`default_nettype none
`include "bmd_consts.svh"
module bmd_cond (
  input wire logic [3:0] cond_sel,
  input var bmd_pkg::bmd_flags_t flags,
  input wire logic irq_level,
  output logic taken
);
  always_comb begin
    case (cond_sel)
      4'h0: taken = 1'b1;
      4'h1: taken = 1'b0;
      4'h2: taken = ~(flags.carry | flags.zero);
      4'h3: taken = flags.carry | flags.zero;
      4'h4: taken = ~flags.carry;
      4'h5: taken = flags.carry;
      4'h6: taken = ~flags.zero;
      4'h7: taken = flags.zero;
      4'h8: taken = flags.half;
      4'h9: taken = ~flags.half;
      4'ha: taken = ~flags.neg;
      4'hb: taken = flags.neg;
      4'hc: taken = ~flags.imask;
      4'hd: taken = flags.imask;
      4'he: taken = ~irq_level;
      4'hf: taken = irq_level;
      default: taken = 1'b0;
    endcase
  end
endmodule : bmd_cond
`default_nettype wire

// ### verilog/bmd_decoder.sv
// opcode decoder for the relative jump group and the miscellaneous group
`default_nettype none
`include "bmd_consts.svh"
module bmd_decoder (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input var bmd_pkg::bmd_flags_t flags,
  input wire logic irq_pin,
  output var bmd_pkg::bmd_dec_t dec_out
);
  // irq pin is asynchronous: three stages, change accepted when 2nd and 3rd agree
  logic irq_s1_ff, irq_s2_ff, irq_s3_ff, irq_lvl_ff;
  logic nxt_irq_s1, nxt_irq_s2, nxt_irq_s3, nxt_irq_lvl;
  logic pfx_ff, nxt_pfx;
  bmd_pkg::bmd_dec_t dec_ff, nxt_dec;
  logic cond_taken;

  bmd_cond u_cond (
    .cond_sel(byte_in[3:0]),
    .flags(flags),
    .irq_level(irq_lvl_ff),
    .taken(cond_taken)
  );

  function automatic bmd_pkg::bmd_dec_t one_byte(input bmd_pkg::bmd_class_t c,
                                                 input logic [3:0] cyc,
                                                 input bmd_pkg::bmd_reg_t s,
                                                 input bmd_pkg::bmd_reg_t d,
                                                 input logic fv);
    bmd_pkg::bmd_dec_t r;
    r = '0;
    r.valid = 1'b1;
    r.cls = c;
    r.length = `BMD_LEN_ONE;
    r.cycles = cyc;
    r.src = s;
    r.dst = d;
    r.flag_val = fv;
    return r;
  endfunction : one_byte

  // a relative form is two bytes; the prefix adds one
  function automatic logic [2:0] rel_len(input logic ind);
    return ind ? `BMD_LEN_IND : `BMD_LEN_REL;
  endfunction : rel_len

  // unknown codes still answer, so the fetch side never stalls on a missing decode
  function automatic bmd_pkg::bmd_dec_t illegal_code(input logic ind);
    bmd_pkg::bmd_dec_t r;
    r = '0;
    r.valid = 1'b1;
    r.cls = bmd_pkg::BMD_ILLEGAL;
    r.indirect = ind;
    r.length = ind ? `BMD_LEN_REL : `BMD_LEN_ONE;
    return r;
  endfunction : illegal_code

  always_comb begin
    nxt_irq_s1 = irq_pin;
    nxt_irq_s2 = irq_s1_ff;
    nxt_irq_s3 = irq_s2_ff;
    nxt_irq_lvl = (irq_s2_ff == irq_s3_ff) ? irq_s3_ff : irq_lvl_ff;
  end

  always_comb begin
    nxt_pfx = pfx_ff;
    nxt_dec = '0;
    if (byte_valid) begin
      nxt_pfx = 1'b0;
      if (!pfx_ff && byte_in == `BMD_PFX_IND) begin
        nxt_pfx = 1'b1; // prefix is held until the opcode byte arrives
      end else if (byte_in[7:4] == 4'h2) begin
        nxt_dec.valid = 1'b1;
        nxt_dec.cls = bmd_pkg::BMD_BRANCH;
        nxt_dec.indirect = pfx_ff;
        nxt_dec.length = rel_len(pfx_ff);
        nxt_dec.cycles = pfx_ff ? `BMD_CYC_IND : `BMD_CYC_REL;
        nxt_dec.taken = cond_taken;
      end else if (byte_in == `BMD_OP_CALL_REL) begin
        nxt_dec.valid = 1'b1;
        nxt_dec.cls = bmd_pkg::BMD_CALL_REL;
        nxt_dec.indirect = pfx_ff;
        nxt_dec.taken = 1'b1;
        nxt_dec.length = rel_len(pfx_ff);
        nxt_dec.cycles = pfx_ff ? `BMD_CYC_CALL_IND : `BMD_CYC_CALL;
      end else if (!pfx_ff) begin
        // misc group has no prefixed forms; a prefixed one decodes illegal
        case (byte_in)
          `BMD_OP_MUL: begin
            nxt_dec = one_byte(bmd_pkg::BMD_PRODUCT,
              `BMD_CYC_MUL,
              bmd_pkg::BMD_R_X,
              bmd_pkg::BMD_R_A,
              1'b0);
          end
          `BMD_OP_LD_XA: begin
            nxt_dec = one_byte(bmd_pkg::BMD_MOVE,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_A,
              bmd_pkg::BMD_R_X,
              1'b0);
          end
          `BMD_OP_LD_AX: begin
            nxt_dec = one_byte(bmd_pkg::BMD_MOVE,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_X,
              bmd_pkg::BMD_R_A,
              1'b0);
          end
          `BMD_OP_LD_SA: begin
            nxt_dec = one_byte(bmd_pkg::BMD_MOVE,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_A,
              bmd_pkg::BMD_R_SP,
              1'b0);
          end
          `BMD_OP_LD_AS: begin
            nxt_dec = one_byte(bmd_pkg::BMD_MOVE,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_SP,
              bmd_pkg::BMD_R_A,
              1'b0);
          end
          `BMD_OP_LD_SX: begin
            nxt_dec = one_byte(bmd_pkg::BMD_MOVE,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_X,
              bmd_pkg::BMD_R_SP,
              1'b0);
          end
          `BMD_OP_LD_XS: begin
            nxt_dec = one_byte(bmd_pkg::BMD_MOVE,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_SP,
              bmd_pkg::BMD_R_X,
              1'b0);
          end
          `BMD_OP_LD_XY: begin
            nxt_dec = one_byte(bmd_pkg::BMD_MOVE,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_Y,
              bmd_pkg::BMD_R_X,
              1'b0);
          end
          `BMD_OP_PUSH_A: begin
            nxt_dec = one_byte(bmd_pkg::BMD_PUSH,
              `BMD_CYC_PUSH,
              bmd_pkg::BMD_R_A,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          `BMD_OP_POP_A: begin
            nxt_dec = one_byte(bmd_pkg::BMD_POP,
              `BMD_CYC_POP,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_A,
              1'b0);
          end
          `BMD_OP_PUSH_X: begin
            nxt_dec = one_byte(bmd_pkg::BMD_PUSH,
              `BMD_CYC_PUSH,
              bmd_pkg::BMD_R_X,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          `BMD_OP_POP_X: begin
            nxt_dec = one_byte(bmd_pkg::BMD_POP,
              `BMD_CYC_POP,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_X,
              1'b0);
          end
          `BMD_OP_PUSH_CC: begin
            nxt_dec = one_byte(bmd_pkg::BMD_PUSH,
              `BMD_CYC_PUSH,
              bmd_pkg::BMD_R_CC,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          `BMD_OP_POP_CC: begin
            nxt_dec = one_byte(bmd_pkg::BMD_POP,
              `BMD_CYC_POP,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_CC,
              1'b0);
          end
          `BMD_OP_RCF: begin
            nxt_dec = one_byte(bmd_pkg::BMD_FLAG,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_CC,
              1'b0);
          end
          `BMD_OP_SCF: begin
            nxt_dec = one_byte(bmd_pkg::BMD_FLAG,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_CC,
              1'b1);
          end
          `BMD_OP_RIM: begin
            nxt_dec = one_byte(bmd_pkg::BMD_FLAG,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_CC,
              1'b0);
          end
          `BMD_OP_SIM: begin
            nxt_dec = one_byte(bmd_pkg::BMD_FLAG,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_CC,
              1'b1);
          end
          `BMD_OP_RSP: begin
            nxt_dec = one_byte(bmd_pkg::BMD_SP_REINIT,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_SP,
              1'b0);
          end
          `BMD_OP_NOP: begin
            nxt_dec = one_byte(bmd_pkg::BMD_NOP,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          `BMD_OP_INTERRUPT_EXIT: begin
            nxt_dec = one_byte(bmd_pkg::BMD_INT_EXIT,
              `BMD_CYC_INTERRUPT_EXIT,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          `BMD_OP_RET: begin
            nxt_dec = one_byte(bmd_pkg::BMD_SUB_EXIT,
              `BMD_CYC_RET,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          `BMD_OP_TRAP: begin
            nxt_dec = one_byte(bmd_pkg::BMD_TRAP,
              `BMD_CYC_TRAP,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          `BMD_OP_HALT: begin
            nxt_dec = one_byte(bmd_pkg::BMD_HALT,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          `BMD_OP_WFI: begin
            nxt_dec = one_byte(bmd_pkg::BMD_WAIT,
              `BMD_CYC_TWO,
              bmd_pkg::BMD_R_NONE,
              bmd_pkg::BMD_R_NONE,
              1'b0);
          end
          default: begin
            nxt_dec = illegal_code(1'b0);
          end
        endcase
      end else begin
        nxt_dec = illegal_code(1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_s1_ff <= 1'b0;
      irq_s2_ff <= 1'b0;
      irq_s3_ff <= 1'b0;
      irq_lvl_ff <= 1'b0;
    end else begin
      irq_s1_ff <= nxt_irq_s1;
      irq_s2_ff <= nxt_irq_s2;
      irq_s3_ff <= nxt_irq_s3;
      irq_lvl_ff <= nxt_irq_lvl;
    end
  end

  // prefix and answer reset together so a half-seen prefixed pair never survives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pfx_ff <= 1'b0;
      dec_ff <= '0;
    end else begin
      pfx_ff <= nxt_pfx;
      dec_ff <= nxt_dec;
    end
  end

  assign dec_out = dec_ff;
endmodule : bmd_decoder
`default_nettype wire

// ### bench/bmd_decoder_props.sv
// concurrent checks on the decoder ports
`default_nettype none
`include "bmd_consts.svh"
module bmd_decoder_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input var bmd_pkg::bmd_flags_t flags,
  input wire logic irq_pin,
  input var bmd_pkg::bmd_dec_t dec_out
);
  logic pend_ff;
  logic nxt_pend;
  // mirrors the pending prefix; a second prefix counts as an opcode
  always_comb begin
    nxt_pend = pend_ff;
    if (byte_valid) nxt_pend = (byte_in == `BMD_PFX_IND) && !pend_ff;
    if (rst) nxt_pend = 1'b0;
  end
  always_ff @(posedge ref_clk) begin
    pend_ff <= nxt_pend;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_op(logic [7:0] op);
    byte_valid && !pend_ff && byte_in == op;
  endsequence
  sequence s_jr(logic p);
    byte_valid && pend_ff == p && byte_in[7:4] == 4'h2;
  endsequence
  a_prefix_silent: assert property (s_op(`BMD_PFX_IND) |=> !dec_out.valid)
    else $error("prefix byte produced an answer");
  a_idle_quiet: assert property (!byte_valid |=> !dec_out.valid)
    else $error("answer without a byte");
  a_rel_shape: assert property (s_jr(1'b0) |=>
    dec_out.valid && dec_out.length == `BMD_LEN_REL && dec_out.cycles == `BMD_CYC_REL)
    else $error("relative branch shape");
  a_ind_shape: assert property (s_jr(1'b1) |=>
    dec_out.indirect && dec_out.length == `BMD_LEN_IND && dec_out.cycles == `BMD_CYC_IND)
    else $error("indirect branch shape");
  a_carry_taken: assert property (s_op(8'h25) |=> dec_out.taken == $past(flags.carry))
    else $error("carry branch decision");
  a_above_taken: assert property (s_op(8'h22) |=>
    dec_out.taken == !($past(flags.carry) || $past(flags.zero)))
    else $error("above decision");
  a_zero_taken: assert property (s_op(8'h27) |=> dec_out.taken == $past(flags.zero))
    else $error("zero branch decision");
  a_mul_timing: assert property (s_op(`BMD_OP_MUL) |=>
    dec_out.cycles == `BMD_CYC_MUL && dec_out.length == `BMD_LEN_ONE)
    else $error("multiply timing");
  a_call_timing: assert property (byte_valid && byte_in == `BMD_OP_CALL_REL |=>
    dec_out.cycles == ($past(pend_ff) ? `BMD_CYC_CALL_IND : `BMD_CYC_CALL))
    else $error("call timing");
  a_pop_timing: assert property (byte_valid && !pend_ff &&
    byte_in inside {8'h84, 8'h85, 8'h86} |=> dec_out.cycles == `BMD_CYC_POP)
    else $error("pop timing");
endmodule : bmd_decoder_props
bind bmd_decoder bmd_decoder_props i_props (.ref_clk(ref_clk), .rst(rst),
  .byte_valid(byte_valid), .byte_in(byte_in), .flags(flags), .irq_pin(irq_pin),
  .dec_out(dec_out));
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the branch and misc decoder
`default_nettype none
`include "bmd_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic byte_valid = 1'b0;
  logic [7:0] byte_in = 8'h00;
  bmd_pkg::bmd_flags_t flags = '0;
  logic irq_pin = 1'b0;
  bmd_pkg::bmd_dec_t dec_out;
  int error_cnt = 0;
  int checked = 0;
  // opcode, class, cycles
  logic [15:0] misc_tab [25] = '{16'h423b, 16'h9742, 16'h9f42, 16'h9542, 16'h9e42,
    16'h9442, 16'h9642, 16'h9342, 16'h8853, 16'h8953, 16'h8a53, 16'h8464, 16'h8564,
    16'h8664, 16'h9872, 16'h9972, 16'h9a72, 16'h9b72, 16'h9c82, 16'h9d92, 16'h80a9,
    16'h81b6, 16'h83ca, 16'h8ed2, 16'h8fe2};
  // opcode, source, destination
  logic [15:0] mv_tab [8] = '{16'h9712, 16'h9f21, 16'h9514, 16'h9e41, 16'h9424,
    16'h9642, 16'h9332, 16'h4221};
  always #50 ref_clk = ~ref_clk;
  bmd_decoder i_dut (.ref_clk(ref_clk), .rst(rst), .byte_valid(byte_valid),
    .byte_in(byte_in), .flags(flags), .irq_pin(irq_pin), .dec_out(dec_out));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // holds the byte over one edge; valid stays up so bytes can run back to back
  task automatic send(input logic [7:0] b);
    byte_in = b;
    byte_valid = 1'b1;
    @(posedge ref_clk) #10;
  endtask : send
  task automatic dec(input logic p, input logic [7:0] op);
    @(posedge ref_clk) #10;
    if (p) send(`BMD_PFX_IND);
    send(op);
    byte_valid = 1'b0;
  endtask : dec
  function automatic logic exp_taken(input logic [3:0] c, input bmd_pkg::bmd_flags_t f,
    input logic q);
    logic [15:0] v;
    v = {q, !q, f.imask, !f.imask, f.neg, !f.neg, !f.half, f.half, f.zero, !f.zero,
      f.carry, !f.carry, f.carry | f.zero, !(f.carry | f.zero), 1'b0, 1'b1};
    return v[c];
  endfunction : exp_taken
  task automatic t_branches;
    logic [4:0] fset [4] = '{5'h00, 5'h1f, 5'h14, 5'h0b};
    logic t;
    for (int s = 0; s < 4; s++) begin
      flags = fset[s];
      irq_pin = s[0];
      // the pin passes a synchroniser, so let it settle first
      repeat (8) @(posedge ref_clk);
      for (int k = 0; k < 32; k++) begin
        dec(k[4], {4'h2, k[3:0]});
        t = exp_taken(k[3:0], flags, irq_pin);
        case (k[3:1])
          3'h0: chk(dec_out.taken, t);
          3'h1: chk(dec_out.taken, t);
          3'h2: chk(dec_out.taken, t);
          3'h3: chk(dec_out.taken, t);
          3'h4: chk(dec_out.taken, t);
          3'h5: chk(dec_out.taken, t);
          3'h6: chk(dec_out.taken, t);
          default: chk(dec_out.taken, t);
        endcase
        chk(dec_out.cycles, k[4] ? `BMD_CYC_IND : `BMD_CYC_REL);
        chk(dec_out.length, k[4] ? `BMD_LEN_IND : `BMD_LEN_REL);
        chk(dec_out.indirect, k[4]);
        chk(dec_out.cls, bmd_pkg::BMD_BRANCH);
      end
    end
  endtask : t_branches
  task automatic t_misc;
    logic [15:0] e;
    for (int i = 0; i < 25; i++) begin
      e = misc_tab[i];
      dec(1'b0, e[15:8]);
      chk(dec_out.cls, {4'h0, e[7:4]});
      chk(dec_out.cycles, e[3:0]);
      chk(dec_out.length, `BMD_LEN_ONE);
      if (e[7:4] == 4'h7) chk(dec_out.flag_val, e[8]);
    end
    for (int i = 0; i < 8; i++) begin
      e = mv_tab[i];
      dec(1'b0, e[15:8]);
      chk(dec_out.src, e[7:4]);
      chk(dec_out.dst, e[3:0]);
    end
  endtask : t_misc
  task automatic t_prefix;
    @(posedge ref_clk) #10;
    send(`BMD_PFX_IND);
    chk(dec_out.valid, 1'b0);
    byte_valid = 1'b0;
    repeat (3) @(posedge ref_clk);
    #10;
    send(`BMD_OP_CALL_REL);
    chk(dec_out.cycles, `BMD_CYC_CALL_IND);
    chk(dec_out.length, `BMD_LEN_IND);
    chk(dec_out.indirect, 1'b1);
    send(`BMD_OP_NOP);
    chk(dec_out.cls, bmd_pkg::BMD_NOP);
    send(`BMD_PFX_IND);
    send(`BMD_OP_NOP);
    chk(dec_out.cls, bmd_pkg::BMD_ILLEGAL);
    send(`BMD_PFX_IND);
    send(`BMD_PFX_IND);
    chk(dec_out.valid, 1'b1);
    chk(dec_out.cls, bmd_pkg::BMD_ILLEGAL);
    chk(dec_out.length, `BMD_LEN_REL);
    byte_valid = 1'b0;
    dec(1'b0, `BMD_OP_CALL_REL);
    chk(dec_out.cycles, `BMD_CYC_CALL);
    chk(dec_out.length, `BMD_LEN_REL);
    chk(dec_out.taken, 1'b1);
  endtask : t_prefix
  // a pending prefix must not survive a reset in mid-run, and a byte met by reset is dropped
  task automatic t_reset;
    @(posedge ref_clk) #10;
    send(`BMD_PFX_IND);
    byte_in = 8'h27;
    rst = 1'b1;
    @(posedge ref_clk) #10;
    chk(dec_out.valid, 1'b0);
    byte_valid = 1'b0;
    rst = 1'b0;
    dec(1'b0, 8'h27);
    chk(dec_out.length, `BMD_LEN_REL);
    chk(dec_out.indirect, 1'b0);
  endtask : t_reset
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge ref_clk);
    #10;
    rst = 1'b0;
    t_branches();
    t_misc();
    t_prefix();
    t_reset();
    print_verdict();
  end
  // the tests need well under a thousand cycles
  initial begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
